// *** wiper_chain_params.svh ***
`ifndef WIPER_CHAIN_PARAMS_SVH
`define WIPER_CHAIN_PARAMS_SVH

`define CHAIN_BITS 48
`define CHAIN_FIELDS 6
`define FIELD_BITS 8
`define POS_BITS 6
`define KEEP_HI 7
`define KEEP_LO 6
`define WIPER_RESET 6'h00
`define FIELD_RESET 8'h00
`define CLK_RATE_MHZ 50
`define LINK_HALF_NS 80
`define LINK_HALF_CYC ((`LINK_HALF_NS * `CLK_RATE_MHZ) / 1000)
`define SEL_GAP_NS 125
`define SEL_GAP_CYC (((`SEL_GAP_NS * `CLK_RATE_MHZ) + 999) / 1000)

`endif

// *** wiper_chain_pkg.sv ***
`default_nettype none
package wiper_chain_pkg;
    typedef logic [5:0] wiper_pos_t;
    typedef logic [47:0] chain_word_t;
    typedef enum logic [3:0] {
        HS_IDLE = 4'h1,
        HS_LOW = 4'h2,
        HS_HIGH = 4'h4,
        HS_END = 4'h8
    } host_state_t;
endpackage : wiper_chain_pkg
`default_nettype wire

// *** wiper_link_if.sv ***
`timescale 1ns/100ps
`default_nettype none
interface wiper_link_if;
    logic serial_select;
    logic shift_clk;
    logic host_data_o;
    logic host_data_oe;
    logic chain_out;
    logic serial_in;
    // Host drives the data line while enabled; else the feedback loop does.
    assign serial_in = host_data_oe ? host_data_o : chain_out;
    modport device (
        input serial_select,
        input shift_clk,
        input serial_in,
        output chain_out
    );
    modport host (
        output serial_select,
        output shift_clk,
        output host_data_o,
        output host_data_oe,
        input serial_in
    );
endinterface : wiper_link_if
`default_nettype wire

// *** wiper_chain_device.sv ***
`include "wiper_chain_params.svh"
`timescale 1ns/100ps
`default_nettype none
module wiper_chain_device
    import wiper_chain_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Serial link.
    wiper_link_if.device link,
    // Wiper positions, 0 is low_terminal and 63 is high_terminal.
    output logic [`CHAIN_FIELDS*`POS_BITS-1:0] WIPER_POS_O,
    // Raw shift register contents.
    output logic [`CHAIN_BITS-1:0] SHIFT_REG_O
);
    // Pin synchronisers; bit 0 is the first flop, bit 1 the second.
    logic [2:0] sel_sync;
    logic [2:0] clk_sync;
    logic [1:0] din_sync;

    // Edge and enable terms, all taken after the second flop.
    logic sel_now;
    logic sel_rise;
    logic sel_fall;
    logic clk_rise;
    logic port_active;
    logic shift_en;
    logic apply_en;

    // Shift register and its next value.
    chain_word_t shift_reg;
    chain_word_t next_shift_reg;
    logic next_chain_out;

    // Wiper positions, packed six bits per field, pot 1 lowest.
    logic [`CHAIN_FIELDS*`POS_BITS-1:0] wiper;
    logic [`CHAIN_FIELDS*`POS_BITS-1:0] next_wiper;
    logic [`CHAIN_FIELDS-1:0] field_keep;

    // The third flop of select and clock only serves edge detection.
    // Its reset value matches the idle pin level, so no false edge.
    always_comb begin
        sel_now = sel_sync[1];
        sel_rise = sel_sync[1] & ~sel_sync[2];
        sel_fall = ~sel_sync[1] & sel_sync[2];
        clk_rise = clk_sync[1] & ~clk_sync[2];
    end

    // Clock edges count only inside a frame opened by a select rise.
    always_comb begin
        shift_en = 1'b0;
        if (port_active && sel_now && clk_rise) begin
            shift_en = 1'b1;
        end
    end

    // Settings are applied only at the close of an opened frame.
    // A select fall without a frame leaves every wiper alone.
    always_comb begin
        apply_en = 1'b0;
        if (port_active && sel_fall) begin
            apply_en = 1'b1;
        end
    end

    // The select pin passes two flops before any logic reads it.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            sel_sync <= 3'h0;
        end else begin
            sel_sync <= {sel_sync[1:0], link.serial_select};
        end
    end

    // The shift clock pin is sampled like any other pin.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            clk_sync <= 3'h0;
        end else begin
            clk_sync <= {clk_sync[1:0], link.shift_clk};
        end
    end

    // The data pin lags the clock edge by the same two flops.
    // Data therefore pairs with the clock rise that it preceded.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            din_sync <= 2'h0;
        end else begin
            din_sync <= {din_sync[0], link.serial_in};
        end
    end

    // The port wakes on a select rise and sleeps while select is low.
    // A select held high out of reset opens a frame, as its flops reset low.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            port_active <= 1'b0;
        end else if (!sel_now) begin
            port_active <= 1'b0;
        end else if (sel_rise) begin
            port_active <= 1'b1;
        end
    end

    // Each stage takes its upper neighbour; the pin enters stage 47.
    // After 48 shifts the first bit sent sits in stage 0.
    genvar b;
    generate
        for (b = 0; b < `CHAIN_BITS; b++) begin : g_stage
            if (b == `CHAIN_BITS - 1) begin : g_first
                assign next_shift_reg[b] = shift_en ? din_sync[1]
                    : shift_reg[b];
            end else begin : g_inner
                assign next_shift_reg[b] = shift_en ? shift_reg[b+1]
                    : shift_reg[b];
            end
        end
    endgenerate

    // The shift register holds six byte fields.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            shift_reg <= '0;
        end else begin
            shift_reg <= next_shift_reg;
        end
    end

    // Stage 0 is the last stage and holds pot 1 LSB.
    // The output follows the new stage 0 in the same cycle as the shift.
    always_comb begin
        next_chain_out = next_shift_reg[0];
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            link.chain_out <= 1'b0;
        end else begin
            link.chain_out <= next_chain_out;
        end
    end

    // A field whose top two bits are both one keeps its wiper.
    genvar g;
    generate
        for (g = 0; g < `CHAIN_FIELDS; g++) begin : g_keep
            assign field_keep[g] = shift_reg[g*`FIELD_BITS+`KEEP_HI]
                & shift_reg[g*`FIELD_BITS+`KEEP_LO];
        end
    endgenerate

    // Every other field loads its low six bits at frame close.
    // Code 0 is the low_terminal end and code 63 the high_terminal end.
    generate
        for (g = 0; g < `CHAIN_FIELDS; g++) begin : g_apply
            assign next_wiper[g*`POS_BITS +: `POS_BITS] =
                (apply_en && !field_keep[g])
                ? shift_reg[g*`FIELD_BITS +: `POS_BITS]
                : wiper[g*`POS_BITS +: `POS_BITS];
        end
    endgenerate

    // Wipers start at the low end and move only at frame close.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            wiper <= {`CHAIN_FIELDS{`WIPER_RESET}};
        end else begin
            wiper <= next_wiper;
        end
    end

    // The wiper outputs are a registered copy of the positions.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            WIPER_POS_O <= {`CHAIN_FIELDS{`WIPER_RESET}};
        end else begin
            WIPER_POS_O <= wiper;
        end
    end

    // The raw register copy lets a user watch the chain contents.
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            SHIFT_REG_O <= '0;
        end else begin
            SHIFT_REG_O <= shift_reg;
        end
    end
endmodule : wiper_chain_device
`default_nettype wire

// *** wiper_chain_host.sv ***
`include "wiper_chain_params.svh"
`timescale 1ns/100ps
`default_nettype none
module wiper_chain_host
    import wiper_chain_pkg::*;
(
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Serial link.
    wiper_link_if.host link,
    // Request: write sends WORD_I; read recirculates with data released.
    input wire logic START_I,
    input wire logic READ_I,
    input wire logic [`CHAIN_BITS-1:0] WORD_I,
    // Answer.
    output logic BUSY_O,
    output logic DONE_O,
    output logic [`CHAIN_BITS-1:0] WORD_O
);
    host_state_t state;
    logic [7:0] half_cnt;
    logic [5:0] bit_cnt;
    chain_word_t tx;
    logic reading;
    logic [1:0] din_sync;

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            din_sync <= 2'h0;
        end else begin
            din_sync <= {din_sync[0], link.serial_in};
        end
    end

    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I) begin
            state <= HS_IDLE;
            half_cnt <= 8'h00;
            bit_cnt <= 6'h00;
            tx <= '0;
            reading <= 1'b0;
            link.serial_select <= 1'b0;
            link.shift_clk <= 1'b0;
            link.host_data_o <= 1'b0;
            link.host_data_oe <= 1'b0;
            BUSY_O <= 1'b0;
            DONE_O <= 1'b0;
            WORD_O <= '0;
        end else begin
            DONE_O <= 1'b0;
            case (state)
                HS_IDLE: begin
                    if (START_I) begin
                        tx <= WORD_I;
                        reading <= READ_I;
                        link.serial_select <= 1'b1;
                        link.host_data_oe <= ~READ_I;
                        link.host_data_o <= WORD_I[0];
                        bit_cnt <= 6'h00;
                        half_cnt <= 8'h00;
                        BUSY_O <= 1'b1;
                        state <= HS_LOW;
                    end
                end
                HS_LOW: begin
                    half_cnt <= half_cnt + 8'h01;
                    if (half_cnt == 8'(`LINK_HALF_CYC - 1)) begin
                        half_cnt <= 8'h00;
                        link.shift_clk <= 1'b1;
                        WORD_O <= {din_sync[1], WORD_O[`CHAIN_BITS-1:1]};
                        state <= HS_HIGH;
                    end
                end
                HS_HIGH: begin
                    half_cnt <= half_cnt + 8'h01;
                    if (half_cnt == 8'(`LINK_HALF_CYC - 1)) begin
                        half_cnt <= 8'h00;
                        link.shift_clk <= 1'b0;
                        tx <= {1'b0, tx[`CHAIN_BITS-1:1]};
                        link.host_data_o <= tx[1];
                        bit_cnt <= bit_cnt + 6'h01;
                        if (bit_cnt == 6'(`CHAIN_BITS - 1)) begin
                            state <= HS_END;
                        end else begin
                            state <= HS_LOW;
                        end
                    end
                end
                HS_END: begin
                    half_cnt <= half_cnt + 8'h01;
                    if (half_cnt == 8'(`LINK_HALF_CYC - 1)) begin
                        link.serial_select <= 1'b0;
                        link.host_data_oe <= 1'b0;
                    end
                    if (half_cnt == 8'(`LINK_HALF_CYC + `SEL_GAP_CYC)) begin
                        half_cnt <= 8'h00;
                        BUSY_O <= 1'b0;
                        DONE_O <= 1'b1;
                        state <= HS_IDLE;
                    end
                end
                default: begin
                    state <= HS_IDLE;
                end
            endcase
        end
    end
endmodule : wiper_chain_host
`default_nettype wire

// *** wiper_chain_asserts.sv ***
`timescale 1ns/100ps
`default_nettype none
module wiper_chain_asserts (
    // Clock and reset.
    input wire logic REF_CLK_I,
    input wire logic RST_N_I,
    // Link signals.
    input wire logic serial_select,
    input wire logic shift_clk,
    input wire logic host_data_o,
    input wire logic host_data_oe,
    input wire logic chain_out,
    input wire logic serial_in
);
    logic [6:0] rises;
    always_ff @(posedge REF_CLK_I) begin
        if (!RST_N_I || !serial_select) begin
            rises <= 7'h00;
        end else if ($rose(shift_clk)) begin
            rises <= rises + 7'h01;
        end
    end
    default clocking cb @(posedge REF_CLK_I); endclocking
    default disable iff (!RST_N_I);
    AST_CHAIN_HOLD: assert property (
        !serial_select && !$past(serial_select, 4) |-> $stable(chain_out))
        else $error("chain moved while idle");
    AST_CHAIN_ON_CLK: assert property (
        $changed(chain_out) |-> $past(shift_clk))
        else $error("chain moved without clock");
    AST_FIRST_BIT: assert property (
        $rose(serial_select) |-> $stable(chain_out)[*4])
        else $error("first bit not held");
    AST_CLK_IN_FRAME: assert property (
        $rose(shift_clk) |-> serial_select)
        else $error("clock outside frame");
    AST_CLK_HIGH: assert property (
        $rose(shift_clk) |=> shift_clk[*3] ##1 !shift_clk)
        else $error("clock high width");
    AST_CLK_LOW: assert property (
        $fell(shift_clk) |=> !shift_clk[*3])
        else $error("clock low width");
    AST_BIT_COUNT: assert property (
        $fell(serial_select) |-> rises == 7'h30)
        else $error("bit count");
    AST_DATA_HOLD: assert property (
        shift_clk && host_data_oe |-> $stable(host_data_o))
        else $error("data moved while clock high");
endmodule : wiper_chain_asserts
`default_nettype wire

// *** six_wiper_serial_chain_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module six_wiper_serial_chain_tb;
    import wiper_chain_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic start = 1'b0;
    logic rd = 1'b0;
    chain_word_t wd = '0;
    logic busy, done;
    chain_word_t wo, sr, cur;
    logic [35:0] wip, exp_wip;
    int err_total = 0;
    int checks = 0;
    wiper_link_if link ();
    wiper_chain_device u_wiper_chain_device (.REF_CLK_I(clk),
        .RST_N_I(rst_n), .link(link.device), .WIPER_POS_O(wip),
        .SHIFT_REG_O(sr));
    wiper_chain_host u_wiper_chain_host (.REF_CLK_I(clk), .RST_N_I(rst_n),
        .link(link.host), .START_I(start), .READ_I(rd), .WORD_I(wd),
        .BUSY_O(busy), .DONE_O(done), .WORD_O(wo));
    wiper_chain_asserts u_wiper_chain_asserts (.REF_CLK_I(clk),
        .RST_N_I(rst_n), .serial_select(link.serial_select),
        .shift_clk(link.shift_clk), .host_data_o(link.host_data_o),
        .host_data_oe(link.host_data_oe), .chain_out(link.chain_out),
        .serial_in(link.serial_in));
    always #10 clk = ~clk;
    function automatic logic [35:0] nxt(logic [35:0] w, chain_word_t d);
        for (int i = 0; i < 6; i++) begin
            if (d[8*i+7 -: 2] != 2'b11) w[6*i +: 6] = d[8*i +: 6];
        end
        return w;
    endfunction : nxt
    task cmp_word(input chain_word_t got, input chain_word_t exp);
        checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : cmp_word
    task cmp_wip(input logic [35:0] got, input logic [35:0] exp);
        checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : cmp_wip
    task cmp_bit(input logic got, input logic exp);
        checks++;
        if (got !== exp) begin
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
            err_total++;
        end
    endtask : cmp_bit
    task report_and_stop;
        $display("checks=%0d errors=%0d", checks, err_total);
        if (err_total == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task xfer(input logic r, input chain_word_t w);
        int n;
        chain_word_t old;
        old = cur;
        @(posedge clk);
        start <= 1'b1;
        rd <= r;
        wd <= w;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        do begin
            @(negedge clk);
            n++;
        end while (done !== 1'b1 && n < 1000);
        if (n >= 1000) begin
            err_total++;
            report_and_stop();
        end
        if (!r) cur = w;
        exp_wip = nxt(exp_wip, cur);
        if (r) cmp_word(wo, old);
        cmp_word(sr, cur);
        cmp_wip(wip, exp_wip);
        cmp_bit(busy, 1'b0);
        @(negedge clk);
        cmp_bit(done, 1'b0);
    endtask : xfer
    initial begin
        chain_word_t rw;
        void'($urandom(31));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        cur = '0;
        exp_wip = '0;
        @(negedge clk);
        cmp_wip(wip, 36'h0);
        cmp_word(sr, 48'h0);
        xfer(1'b0, 48'h3f00bf7fc53f);
        xfer(1'b1, 48'h0);
        xfer(1'b0, 48'hffffffffffff);
        for (int k = 0; k < 10; k++) begin
            rw = {$urandom(), 16'($urandom())};
            xfer(k[0], rw);
        end
        report_and_stop();
    end
endmodule : six_wiper_serial_chain_tb
`default_nettype wire
